// file: rtl/aprc_ctrl.sv
// Power-state, clock-stop monitor and reset control for an eight-lane converter
//
// Contract
// - Power-down pin high enters full power-down: reference, clock, all channels off.
// - After power-down pin falls, about 500 us before conversion resumes.
// - Each channel may be powered down alone by configuration.
// - Monitor flags partial power-down if sample clock stops over 300 ns or slow.
// - After long clock stop ends, about 100 us to leave partial power-down.
// - After short clock stop, about 10 us recovery, no partial power-down.
// - Reset clears every configuration register to zero.
// - While reset is held, every channel sends an all-zero code.
// - Bit and frame clocks keep toggling during reset.
// - In full power-down all data and clock drivers are high impedance.
`timescale 1ns/1ps
`include "aprc_consts.svh"
module aprc_ctrl #(
	parameter int NUM_CH        = `APRC_NUM_CH,
	parameter int CODE_W        = `APRC_CODE_W,
	parameter int PD_REC_CYC    = `APRC_PD_REC_CYC,
	parameter int LONG_REC_CYC  = `APRC_LONG_REC_CYC,
	parameter int SHORT_REC_CYC = `APRC_SHORT_REC_CYC
) (
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	input  wire logic                     power_down_pin,
	input  wire logic                     sample_clock_in,
	input  wire logic [NUM_CH-1:0]        ch_pd_cfg_wr,
	input  wire logic                     ch_pd_cfg_we,
	input  wire logic [NUM_CH*CODE_W-1:0] conv_codes,
	input  wire logic                     bit_clk_src,
	input  wire logic                     frame_clk_src,
	output logic [NUM_CH*CODE_W-1:0]      lane_codes,
	output logic [NUM_CH-1:0]             lane_oe,
	output logic [NUM_CH-1:0]             ch_pd,
	output logic                          bit_clk_out,
	output logic                          frame_clk_out,
	output logic                          clk_oe,
	output aprc_pkg::aprc_status_t        status
);
	localparam int GAP_W = 8;
	localparam int REC_W = 32;
	localparam logic [GAP_W-1:0] STOP_CYC = GAP_W'(`APRC_STOP_CYC);
	localparam logic [GAP_W-1:0] SLOW_CYC = GAP_W'(`APRC_SLOW_CYC);

	function automatic logic [REC_W-1:0] rec_len(input int cyc);
		rec_len = (cyc < 1) ? REC_W'(1) : REC_W'(cyc);
	endfunction

	aprc_pkg::aprc_state_t state_reg;
	aprc_pkg::aprc_state_t state_next;
	logic [GAP_W-1:0]      gap_reg;
	logic [GAP_W-1:0]      gap_next;
	logic [REC_W-1:0]      rec_reg;
	logic [REC_W-1:0]      rec_next;
	logic                  sclk_prev_reg;
	logic                  stopped_reg;
	logic                  stopped_next;
	logic [NUM_CH-1:0]     ch_pd_reg;
	logic [NUM_CH*CODE_W-1:0] codes_reg;
	logic [NUM_CH-1:0]     lane_oe_reg;
	logic                  clk_oe_reg;
	aprc_pkg::aprc_status_t status_reg;

	// Sample clock taken as a synchronous level; edges counted in core_clk
	wire sclk_edge   = sample_clock_in & ~sclk_prev_reg;
	wire gap_stop    = (gap_reg > STOP_CYC);
	wire gap_slow    = (gap_reg > SLOW_CYC);
	// Slow clock can only be flagged apart from a stop when its period threshold is below the stop one
	wire clk_bad     = gap_stop | gap_slow;
	wire short_stop  = sclk_edge & (gap_reg > 8'h02) & ~gap_stop;
	wire rec_done    = (rec_reg == '0);
	wire in_full_pd  = (state_reg == aprc_pkg::APRC_FULL_PD);

	assign gap_next     = sclk_edge ? '0 : (gap_reg == '1 ? gap_reg : gap_reg + 8'h01);
	// Set wins over the clearing edge, so a late edge still reports the stop
	assign stopped_next = clk_bad | (~sclk_edge & stopped_reg);

	always_comb
	begin
		state_next = state_reg;
		rec_next   = rec_done ? rec_reg : rec_reg - 32'h1;
		unique case (state_reg)
			aprc_pkg::APRC_RUN:
			begin
				if (power_down_pin)
					state_next = aprc_pkg::APRC_FULL_PD;
				else if (clk_bad)
					state_next = aprc_pkg::APRC_PART_PD;
				else if (short_stop)
				begin
					state_next = aprc_pkg::APRC_RECOVER;
					rec_next   = rec_len(SHORT_REC_CYC);
				end
			end
			aprc_pkg::APRC_FULL_PD:
			begin
				if (!power_down_pin)
				begin
					state_next = aprc_pkg::APRC_RECOVER;
					rec_next   = rec_len(PD_REC_CYC);
				end
			end
			aprc_pkg::APRC_PART_PD:
			begin
				if (power_down_pin)
					state_next = aprc_pkg::APRC_FULL_PD;
				else if (sclk_edge)
				begin
					state_next = aprc_pkg::APRC_RECOVER;
					rec_next   = rec_len(LONG_REC_CYC);
				end
			end
			aprc_pkg::APRC_RECOVER:
			begin
				if (power_down_pin)
					state_next = aprc_pkg::APRC_FULL_PD;
				else if (clk_bad)
					state_next = aprc_pkg::APRC_PART_PD;
				else if (rec_done)
					state_next = aprc_pkg::APRC_RUN;
			end
			default:
				state_next = aprc_pkg::APRC_FULL_PD;
		endcase
	end

	// Recovery counter runs on core_clk, independent of the sample clock
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state_reg     <= aprc_pkg::APRC_RECOVER;
			rec_reg       <= 32'h1;
			gap_reg       <= '0;
			sclk_prev_reg <= 1'b0;
			stopped_reg   <= 1'b0;
		end
		else
		begin
			state_reg     <= state_next;
			rec_reg       <= rec_next;
			gap_reg       <= gap_next;
			sclk_prev_reg <= sample_clock_in;
			stopped_reg   <= stopped_next;
		end
	end

	// Channel power-down configuration, cleared by reset
	always_ff @(posedge core_clk)
	begin
		if (rst)
			ch_pd_reg <= NUM_CH'(`APRC_CFG_RST);
		else if (ch_pd_cfg_we)
			ch_pd_reg <= ch_pd_cfg_wr;
	end

	// Output lanes: zero code in reset, drivers off in full power-down
	always_ff @(posedge core_clk)
	begin
		if (rst)
			codes_reg <= '0;
		else
			codes_reg <= conv_codes;
		lane_oe_reg   <= in_full_pd ? '0 : ~ch_pd_reg;
		clk_oe_reg    <= ~in_full_pd;
		bit_clk_out   <= bit_clk_src;
		frame_clk_out <= frame_clk_src;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			status_reg <= '0;
		else
		begin
			status_reg.full_pd    <= in_full_pd;
			status_reg.partial_pd <= (state_reg == aprc_pkg::APRC_PART_PD) | stopped_reg;
			status_reg.data_valid <= (state_reg == aprc_pkg::APRC_RUN);
			status_reg.outputs_oe <= ~in_full_pd;
		end
	end

	assign lane_codes = codes_reg;
	assign lane_oe    = lane_oe_reg;
	assign ch_pd      = ch_pd_reg;
	assign clk_oe     = clk_oe_reg;
	assign status     = status_reg;

	AST_PD_ENTER: assert property (@(posedge core_clk) disable iff (rst)
		(power_down_pin && state_reg == aprc_pkg::APRC_RUN) |=> in_full_pd)
		else $error("power-down pin did not enter full power-down");
	AST_PD_REC: assert property (@(posedge core_clk) disable iff (rst)
		(in_full_pd && !power_down_pin) |=> (rec_reg == rec_len(PD_REC_CYC)))
		else $error("power-down recovery length wrong");
	AST_CH_PD: assert property (@(posedge core_clk) disable iff (rst)
		ch_pd_cfg_we |=> (ch_pd == $past(ch_pd_cfg_wr)))
		else $error("channel power-down not stored");
	AST_STOP: assert property (@(posedge core_clk) disable iff (rst)
		(gap_stop && !power_down_pin && state_reg == aprc_pkg::APRC_RUN)
		|=> (state_reg == aprc_pkg::APRC_PART_PD))
		else $error("clock stop not detected");
	AST_LONG_REC: assert property (@(posedge core_clk) disable iff (rst)
		(state_reg == aprc_pkg::APRC_PART_PD && sclk_edge && !power_down_pin)
		|=> (rec_reg == rec_len(LONG_REC_CYC)))
		else $error("long stop recovery length wrong");
	AST_SHORT_REC: assert property (@(posedge core_clk) disable iff (rst)
		(state_reg == aprc_pkg::APRC_RUN && short_stop && !power_down_pin)
		|=> (state_reg == aprc_pkg::APRC_RECOVER && rec_reg == rec_len(SHORT_REC_CYC)))
		else $error("short stop recovery wrong");
	AST_RST_CFG: assert property (@(posedge core_clk)
		rst |=> (ch_pd == '0 && lane_codes == '0))
		else $error("reset did not clear configuration and codes");
	AST_CLK_RUN: assert property (@(posedge core_clk)
		rst |=> (bit_clk_out == $past(bit_clk_src)))
		else $error("bit clock blocked by reset");
	AST_FRAME_RUN: assert property (@(posedge core_clk)
		rst |=> (frame_clk_out == $past(frame_clk_src)))
		else $error("frame clock blocked by reset");
	AST_HIZ: assert property (@(posedge core_clk) disable iff (rst)
		in_full_pd |=> (!clk_oe && lane_oe == '0))
		else $error("drivers on in full power-down");
	AST_VALID: assert property (@(posedge core_clk) disable iff (rst)
		(state_reg != aprc_pkg::APRC_RUN) |=> !status.data_valid)
		else $error("data marked valid during recovery");

	COV_FULL_PD: cover property (@(posedge core_clk) disable iff (rst)
		in_full_pd ##1 (state_reg == aprc_pkg::APRC_RECOVER));
	COV_PART_PD: cover property (@(posedge core_clk) disable iff (rst)
		(state_reg == aprc_pkg::APRC_PART_PD) ##1 (state_reg == aprc_pkg::APRC_RECOVER));
	COV_SHORT: cover property (@(posedge core_clk) disable iff (rst)
		short_stop && state_reg == aprc_pkg::APRC_RUN);
	COV_RUN: cover property (@(posedge core_clk) disable iff (rst)
		(state_reg == aprc_pkg::APRC_RECOVER) ##1 (state_reg == aprc_pkg::APRC_RUN));
endmodule

// file: rtl/aprc_consts.svh
// Timing counts and constants for the power and reset control block
`ifndef APRC_CONSTS_SVH
`define APRC_CONSTS_SVH
`define APRC_CLK_PERIOD_NS   25
`define APRC_CLK_MHZ         40
`define APRC_NUM_CH          8
`define APRC_CODE_W          12
`define APRC_STOP_NS         300
`define APRC_MIN_FREQ_MHZ    3
`define APRC_PD_REC_US       500
`define APRC_LONG_REC_US     100
`define APRC_SHORT_REC_US    10
// Longest allowed gap between sample clock edges: longest time rounds down
`define APRC_STOP_CYC        (`APRC_STOP_NS / `APRC_CLK_PERIOD_NS)
// Gap beyond which the clock counts as slower than the floor frequency
`define APRC_SLOW_CYC        (`APRC_CLK_MHZ / `APRC_MIN_FREQ_MHZ)
`define APRC_PD_REC_CYC      (`APRC_PD_REC_US * `APRC_CLK_MHZ)
`define APRC_LONG_REC_CYC    (`APRC_LONG_REC_US * `APRC_CLK_MHZ)
`define APRC_SHORT_REC_CYC   (`APRC_SHORT_REC_US * `APRC_CLK_MHZ)
`define APRC_CFG_RST         8'h00
`endif

// file: rtl/aprc_pkg.sv
// Types for the power and reset control block
package aprc_pkg;
	typedef enum logic [3:0] {
		APRC_RUN      = 4'b0001,
		APRC_FULL_PD  = 4'b0010,
		APRC_PART_PD  = 4'b0100,
		APRC_RECOVER  = 4'b1000
	} aprc_state_t;

	typedef struct packed {
		logic       outputs_oe;
		logic       data_valid;
		logic       partial_pd;
		logic       full_pd;
	} aprc_status_t;
endpackage

// file: verification/aprc_host_model.sv
// Host-side model: power-down pin and board sample clock
`timescale 1ns/1ps
module aprc_host_model (
	input  wire logic       core_clk,
	input  wire logic       pd_req,
	input  wire logic [3:0] half_per,
	output logic            power_down_pin,
	output logic            sample_clock_in
);
	logic [3:0] cnt_reg;
	wire        flip = (cnt_reg + 4'h1 >= half_per);
	initial
	begin
		cnt_reg = 4'h0;
		power_down_pin = 1'b0;
		sample_clock_in = 1'b0;
	end
	always @(posedge core_clk)
	begin
		power_down_pin <= pd_req;
		cnt_reg <= (half_per == 4'h0 || flip) ? 4'h0 : cnt_reg + 4'h1;
		// Zero half period parks the clock low, as a stopped board clock
		if (half_per == 4'h0)
			sample_clock_in <= 1'b0;
		else if (flip)
			sample_clock_in <= ~sample_clock_in;
	end
endmodule

// file: verification/test_aprc_ctrl.sv
// Self-checking bench for the power and reset control block
`timescale 1ns/1ps
module test_aprc_ctrl;
	localparam int PD_C = 20;
	localparam int LONG_C = 10;
	localparam int SHORT_C = 5;
	logic                   core_clk, rst, pd_req, we, bsrc, fsrc, pdp, sclk, bout, fout, clk_oe;
	logic [3:0]             half_per;
	logic [7:0]             wr, lane_oe, ch_pd, d;
	logic [95:0]            conv, lane, conv_q;
	logic                   fsrc_q;
	logic [31:0]            seed;
	logic                   saw;
	aprc_pkg::aprc_status_t status;
	int                     n_fail, n_compared, k, h;
	aprc_host_model host (.core_clk(core_clk), .pd_req(pd_req), .half_per(half_per),
		.power_down_pin(pdp), .sample_clock_in(sclk));
	aprc_ctrl #(.PD_REC_CYC(PD_C), .LONG_REC_CYC(LONG_C), .SHORT_REC_CYC(SHORT_C)) dut (
		.core_clk(core_clk), .rst(rst), .power_down_pin(pdp), .sample_clock_in(sclk),
		.ch_pd_cfg_wr(wr), .ch_pd_cfg_we(we), .conv_codes(conv), .bit_clk_src(bsrc),
		.frame_clk_src(fsrc), .lane_codes(lane), .lane_oe(lane_oe), .ch_pd(ch_pd),
		.bit_clk_out(bout), .frame_clk_out(fout), .clk_oe(clk_oe), .status(status));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	function automatic logic [7:0] exp_oe(input logic [7:0] pd);
		return ~pd;
	endfunction
	task automatic finish_test();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		n_compared++;
		if (ok !== 1'b1)
		begin
			n_fail++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// Bounded wait for valid data; overrun ends the run
	task automatic wait_valid(input int lo, input int hi, input string msg);
		int c;
		c = 0;
		while (status.data_valid !== 1'b1 && c < hi)
		begin
			cyc(1);
			c++;
		end
		chk(c >= lo && c < hi, msg);
		if (c >= hi)
			finish_test();
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		seed <= xs(seed);
		conv <= {seed, seed, seed};
		conv_q <= conv;
		fsrc_q <= fsrc;
		bsrc <= ~bsrc;
		fsrc <= seed[3];
	end
	initial
	begin
		n_fail = 0;
		n_compared = 0;
		seed = 32'hf97e;
		{rst, pd_req, we, bsrc, fsrc, wr, conv, half_per} = {5'b10000, 8'h00, 96'h0, 4'h1};
		cyc(11);
		chk(lane === 96'h0, "codes in reset");
		chk(bout === ~bsrc && fout === fsrc_q, "clocks in reset");
		@(posedge core_clk) rst <= 1'b0;
		wait_valid(0, 10, "startup");
		chk(lane === conv_q && fout === fsrc_q && status.outputs_oe === 1'b1, "pass");
		for (k = 0; k < 4; k++)
		begin
			@(posedge core_clk);
			d = (k == 3) ? 8'hff : seed[7:0];
			we <= 1'b1;
			wr <= d;
		end
		@(posedge core_clk) we <= 1'b0;
		#1 chk(ch_pd === d, "channel config");
		cyc(1);
		chk(lane_oe === exp_oe(d), "lane enable");
		@(posedge core_clk) {rst, we, wr} <= {2'b11, 8'h3c};
		@(posedge core_clk) {rst, we} <= 2'b00;
		#1 chk(ch_pd === 8'h00 && lane === 96'h0, "reset clears");
		wait_valid(0, 10, "after reset");
		$display("test config and reset done");
		@(posedge core_clk) pd_req <= 1'b1;
		cyc(5);
		chk(clk_oe === 1'b0 && lane_oe === 8'h00 && status.full_pd === 1'b1, "pd");
		chk(status.outputs_oe === 1'b0 && status.data_valid === 1'b0, "pd status");
		@(posedge core_clk) pd_req <= 1'b0;
		cyc(2);
		wait_valid(PD_C - 2, PD_C + 8, "pd recovery");
		$display("test power-down done");
		// Long stop, short stop, then a clock below the floor rate
		for (k = 0; k < 3; k++)
		begin
			h = (k == 1) ? SHORT_C : LONG_C;
			saw = 1'b0;
			@(posedge core_clk) half_per <= (k == 2) ? 4'h8 : 4'h0;
			repeat ((k == 1) ? 4 : 40)
			begin
				cyc(1);
				saw = saw | status.partial_pd;
			end
			chk(saw === (k != 1), "partial pd");
			@(posedge core_clk) half_per <= 4'h1;
			cyc(3);
			wait_valid((k == 2) ? 0 : h - 4, h + 20, "stop recovery");
			$display("test clock stop %0d done", k);
		end
		finish_test();
	end
endmodule
